//--- design/sfi_pkg.sv
/*
 * sfi_pkg: shared constants of the status flag interrupt unit,
 * i.e. register offsets, bit positions and values after reset.
 * Assumes byte-wide registers on an 8-bit register address.
 */
package sfi_pkg;

    // ************************************************
    // register port geometry
    // ************************************************
    localparam int SFI_AW = 8;
    localparam int SFI_DW = 8;

    // ************************************************
    // register offsets
    // ************************************************
    localparam logic [7:0] SFI_OFS_LIVE_DEV = 8'h0c;
    localparam logic [7:0] SFI_OFS_LIVE_LOCK = 8'h0e;
    localparam logic [7:0] SFI_OFS_LIVE_PLL = 8'h0f;
    localparam logic [7:0] SFI_OFS_STICKY_DEV = 8'h11;
    localparam logic [7:0] SFI_OFS_STICKY_LOCK = 8'h13;
    localparam logic [7:0] SFI_OFS_STICKY_PLL = 8'h14;
    localparam logic [7:0] SFI_OFS_MASK_DEV = 8'h17;
    localparam logic [7:0] SFI_OFS_MASK_INPUT = 8'h18;
    localparam logic [7:0] SFI_OFS_MASK_LOCK = 8'h19;
    localparam logic [7:0] SFI_OFS_MASK_PLL = 8'h1a;

    // ************************************************
    // field positions
    // ************************************************
    localparam int SFI_BIT_SYS_TUNING = 0;
    localparam int SFI_BIT_XTAL_INPUT_MISSING = 1;
    localparam int SFI_BIT_XTAL_SIGNAL_MISSING = 2;
    localparam int SFI_BIT_XTAL_LOCK_ERROR = 3;
    localparam int SFI_BIT_BUS_TIMEOUT = 5;
    localparam int SFI_BIT_PLL_UNLOCKED = 1;
    localparam int SFI_BIT_REF_ABSENT_MODE = 5;
    localparam int SFI_BIT_PLL_TUNING = 5;
    localparam int SFI_LSB_SIGNAL_MISSING = 0;
    localparam int SFI_LSB_FREQ_OFF = 4;
    localparam int SFI_INPUTS = 4;

    // ************************************************
    // values after reset
    // ************************************************
    localparam logic SFI_RST_MASK = 1'b0;
    localparam logic [3:0] SFI_RST_MASK4 = 4'h0;
    localparam logic SFI_RST_STICKY = 1'b0;
    localparam logic SFI_RST_IRQ_N = 1'b1;
    localparam logic [7:0] SFI_RST_RDATA = 8'h00;

    // number of sticky flags kept here
    localparam int SFI_NFLAG = 6;

endpackage

//--- design/sfi_sticky_cell.sv
/*
 * sfi_sticky_cell: one sticky status flag beside its live indicator.
 * Assumes the live level and the clear strobe are on clk already.
 */
`timescale 1ns/1ps

module sfi_sticky_cell
    import sfi_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic live,
    input wire logic wr_en,
    input wire logic wr_bit,
    output logic flag
);

    logic flag_r;
    logic flag_nxt;

    // the live fault always wins, so a clear written while the fault
    // still shows is simply overridden and no event is ever lost
    always_comb begin
        flag_nxt = flag_r;
        if (wr_en && !wr_bit) begin
            flag_nxt = 1'b0;
        end
        if (live) begin
            flag_nxt = 1'b1;
        end
    end

    // flag storage
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flag_r <= SFI_RST_STICKY;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    assign flag = flag_r;

endmodule // sfi_sticky_cell

//--- design/sfi_status_irq.sv
/*
 * sfi_status_irq: device status flags, sticky flags, interrupt masks
 * and the active-low interrupt pin of the clock generator.
 * Assumes live indicators come from monitors on clk, and that the
 * host reaches the registers over a simple byte register port.
 * Assumes write and read strobes are one-cycle pulses; a read and a
 * write to one byte in the same cycle return the value before the write.
 * Masks for monitors kept outside are stored here and only exported.
 */
// Operation
// - live device calibration bit, 1 calibrating
// - live crystal signal missing bit
// - live crystal lock error bit, 1 unlocked
// - live host bus timeout bit
// - live pll calibration bit, 1 calibrating
// - sticky flag per live indicator, until cleared
// - write zero clears only once fault gone
// - interrupt while any unmasked sticky flag set
// - four input signal missing mask bits
// - four input frequency off mask bits
// - pll loss of lock mask bit
// - holdover or freerun entry mask bit
// - pll calibration flag mask bit
// - device level mask bits, default allow
// - mask one ignores flag, flag still sets
// - sticky pll loss of lock flag kept
`timescale 1ns/1ps

module sfi_status_irq
    import sfi_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    // live indicators from the monitors
    input wire logic sys_tuning_active,
    input wire logic crystal_signal_missing,
    input wire logic crystal_lock_error,
    input wire logic host_bus_timeout,
    input wire logic pll_tuning_active,
    input wire logic pll_unlocked,
    // register port
    input wire logic [SFI_AW-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [SFI_DW-1:0] reg_wdata,
    output logic [SFI_DW-1:0] reg_rdata,
    // masks handed to the input monitors outside
    output logic [SFI_INPUTS-1:0] irq_mask_input_signal_missing,
    output logic [SFI_INPUTS-1:0] irq_mask_input_freq_off,
    output logic irq_mask_reference_absent_mode,
    output logic irq_mask_crystal_input_missing,
    // interrupt pin
    output logic irq_n
);

    // ************************************************
    // declarations
    // ************************************************
    // decoded write strobes, one per writable byte
    logic wr_sticky_dev;
    logic wr_sticky_lock;
    logic wr_sticky_pll;
    logic wr_mask_dev;
    logic wr_mask_input;
    logic wr_mask_lock;
    logic wr_mask_pll;

    // sticky flags as they read back
    logic sys_tuning_active_sticky;
    logic crystal_signal_missing_sticky;
    logic crystal_lock_error_sticky;
    logic host_bus_timeout_sticky;
    logic pll_tuning_active_sticky;
    logic pll_unlocked_sticky;

    // mask registers, one bit per source or input
    logic irq_mask_sys_tuning_r;
    logic irq_mask_crystal_input_missing_r;
    logic irq_mask_crystal_signal_missing_r;
    logic irq_mask_crystal_lock_error_r;
    logic irq_mask_host_bus_timeout_r;
    logic [SFI_INPUTS-1:0] irq_mask_input_signal_missing_r;
    logic [SFI_INPUTS-1:0] irq_mask_input_freq_off_r;
    logic irq_mask_pll_unlocked_r;
    logic irq_mask_reference_absent_mode_r;
    logic irq_mask_pll_tuning_r;

    // pin and read path state
    logic [SFI_NFLAG-1:0] flags;
    logic [SFI_NFLAG-1:0] masks;
    logic irq_n_r;
    logic irq_n_nxt;
    logic [SFI_DW-1:0] rdata_r;
    logic [SFI_DW-1:0] rdata_nxt;

    // ************************************************
    // write decode
    // ************************************************
    // live registers take no write; an unmapped write is dropped
    // the decode is combinational: the strobe is already on clk
    assign wr_sticky_dev = reg_wr && (reg_addr == SFI_OFS_STICKY_DEV);
    assign wr_sticky_lock = reg_wr && (reg_addr == SFI_OFS_STICKY_LOCK);
    assign wr_sticky_pll = reg_wr && (reg_addr == SFI_OFS_STICKY_PLL);
    assign wr_mask_dev = reg_wr && (reg_addr == SFI_OFS_MASK_DEV);
    assign wr_mask_input = reg_wr && (reg_addr == SFI_OFS_MASK_INPUT);
    assign wr_mask_lock = reg_wr && (reg_addr == SFI_OFS_MASK_LOCK);
    assign wr_mask_pll = reg_wr && (reg_addr == SFI_OFS_MASK_PLL);

    // ************************************************
    // sticky flags
    // ************************************************
    // device calibration flag
    // the four device flags share one strobe and pick their own data bit
    sfi_sticky_cell u_sticky_sys (
        .clk(clk),
        .rstn(rstn),
        .live(sys_tuning_active),
        .wr_en(wr_sticky_dev),
        .wr_bit(reg_wdata[SFI_BIT_SYS_TUNING]),
        .flag(sys_tuning_active_sticky)
    );

    // crystal signal missing flag
    // a clear written while the crystal is still missing is ignored
    sfi_sticky_cell u_sticky_xsig (
        .clk(clk),
        .rstn(rstn),
        .live(crystal_signal_missing),
        .wr_en(wr_sticky_dev),
        .wr_bit(reg_wdata[SFI_BIT_XTAL_SIGNAL_MISSING]),
        .flag(crystal_signal_missing_sticky)
    );

    // crystal lock error flag
    // sets on every cycle the crystal loop reports no lock
    sfi_sticky_cell u_sticky_xlock (
        .clk(clk),
        .rstn(rstn),
        .live(crystal_lock_error),
        .wr_en(wr_sticky_dev),
        .wr_bit(reg_wdata[SFI_BIT_XTAL_LOCK_ERROR]),
        .flag(crystal_lock_error_sticky)
    );

    // host bus timeout flag
    // one timeout cycle is enough to leave this flag set
    sfi_sticky_cell u_sticky_tmo (
        .clk(clk),
        .rstn(rstn),
        .live(host_bus_timeout),
        .wr_en(wr_sticky_dev),
        .wr_bit(reg_wdata[SFI_BIT_BUS_TIMEOUT]),
        .flag(host_bus_timeout_sticky)
    );

    // pll loss of lock flag, its own register
    // its live level is readable too, so software can poll for relock
    sfi_sticky_cell u_sticky_unlock (
        .clk(clk),
        .rstn(rstn),
        .live(pll_unlocked),
        .wr_en(wr_sticky_lock),
        .wr_bit(reg_wdata[SFI_BIT_PLL_UNLOCKED]),
        .flag(pll_unlocked_sticky)
    );

    // pll calibration flag
    // the only flag in the pll sticky byte
    sfi_sticky_cell u_sticky_pcal (
        .clk(clk),
        .rstn(rstn),
        .live(pll_tuning_active),
        .wr_en(wr_sticky_pll),
        .wr_bit(reg_wdata[SFI_BIT_PLL_TUNING]),
        .flag(pll_tuning_active_sticky)
    );

    // ************************************************
    // interrupt masks
    // ************************************************
    // device level masks, all allow after reset
    // bit 1 has no flag here; it is kept for the crystal input monitor
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_mask_sys_tuning_r <= SFI_RST_MASK;
            irq_mask_crystal_input_missing_r <= SFI_RST_MASK;
            irq_mask_crystal_signal_missing_r <= SFI_RST_MASK;
            irq_mask_crystal_lock_error_r <= SFI_RST_MASK;
            irq_mask_host_bus_timeout_r <= SFI_RST_MASK;
        end else if (wr_mask_dev) begin
            irq_mask_sys_tuning_r <= reg_wdata[SFI_BIT_SYS_TUNING];
            irq_mask_crystal_input_missing_r <= reg_wdata[SFI_BIT_XTAL_INPUT_MISSING];
            irq_mask_crystal_signal_missing_r <= reg_wdata[SFI_BIT_XTAL_SIGNAL_MISSING];
            irq_mask_crystal_lock_error_r <= reg_wdata[SFI_BIT_XTAL_LOCK_ERROR];
            irq_mask_host_bus_timeout_r <= reg_wdata[SFI_BIT_BUS_TIMEOUT];
        end
    end

    // per-input masks share one register, highest input in the top bit
    // both nibbles are written together, so a partial update needs a read first
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_mask_input_signal_missing_r <= SFI_RST_MASK4;
            irq_mask_input_freq_off_r <= SFI_RST_MASK4;
        end else if (wr_mask_input) begin
            irq_mask_input_signal_missing_r <=
                reg_wdata[SFI_LSB_SIGNAL_MISSING +: SFI_INPUTS];
            irq_mask_input_freq_off_r <=
                reg_wdata[SFI_LSB_FREQ_OFF +: SFI_INPUTS];
        end
    end

    // lock and holdover masks
    // the holdover mask gates nothing here and only leaves as a port
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_mask_pll_unlocked_r <= SFI_RST_MASK;
            irq_mask_reference_absent_mode_r <= SFI_RST_MASK;
        end else if (wr_mask_lock) begin
            irq_mask_pll_unlocked_r <= reg_wdata[SFI_BIT_PLL_UNLOCKED];
            irq_mask_reference_absent_mode_r <= reg_wdata[SFI_BIT_REF_ABSENT_MODE];
        end
    end

    // pll calibration mask
    // a masked calibration still sets its flag and reads back
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_mask_pll_tuning_r <= SFI_RST_MASK;
        end else if (wr_mask_pll) begin
            irq_mask_pll_tuning_r <= reg_wdata[SFI_BIT_PLL_TUNING];
        end
    end

    // the input monitors live outside, so their masks leave as ports
    assign irq_mask_input_signal_missing = irq_mask_input_signal_missing_r;
    assign irq_mask_input_freq_off = irq_mask_input_freq_off_r;
    assign irq_mask_reference_absent_mode = irq_mask_reference_absent_mode_r;
    assign irq_mask_crystal_input_missing = irq_mask_crystal_input_missing_r;

    // ************************************************
    // interrupt pin
    // ************************************************
    // flags and their masks lined up bit for bit
    // bit order from the bottom: sys, crystal signal, crystal lock, timeout, unlock, pll cal
    assign flags = {pll_tuning_active_sticky, pll_unlocked_sticky,
                    host_bus_timeout_sticky, crystal_lock_error_sticky,
                    crystal_signal_missing_sticky, sys_tuning_active_sticky};
    assign masks = {irq_mask_pll_tuning_r, irq_mask_pll_unlocked_r,
                    irq_mask_host_bus_timeout_r, irq_mask_crystal_lock_error_r,
                    irq_mask_crystal_signal_missing_r, irq_mask_sys_tuning_r};

    // a masked flag still sets and reads back, it only stops driving
    // the pin; the pin rises again once the host clears the last one
    assign irq_n_nxt = ~|(flags & ~masks);

    // registered so the pin never glitches on decode hazards
    // costs one cycle of latency after the flag, far below any host reaction
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_n_r <= SFI_RST_IRQ_N;
        end else begin
            irq_n_r <= irq_n_nxt;
        end
    end

    // the pin is driven both high and low; no open-drain stage inside
    assign irq_n = irq_n_r;

    // ************************************************
    // read path
    // ************************************************
    // live bits are shown as they stand; reserved bits read zero
    always_comb begin
        rdata_nxt = '0;
        case (reg_addr)
            // live bytes
            SFI_OFS_LIVE_DEV: begin
                rdata_nxt[SFI_BIT_SYS_TUNING] = sys_tuning_active;
                rdata_nxt[SFI_BIT_XTAL_SIGNAL_MISSING] = crystal_signal_missing;
                rdata_nxt[SFI_BIT_XTAL_LOCK_ERROR] = crystal_lock_error;
                rdata_nxt[SFI_BIT_BUS_TIMEOUT] = host_bus_timeout;
            end
            SFI_OFS_LIVE_LOCK: begin
                rdata_nxt[SFI_BIT_PLL_UNLOCKED] = pll_unlocked;
            end
            SFI_OFS_LIVE_PLL: begin
                rdata_nxt[SFI_BIT_PLL_TUNING] = pll_tuning_active;
            end
            // sticky bytes
            SFI_OFS_STICKY_DEV: begin
                rdata_nxt[SFI_BIT_SYS_TUNING] = sys_tuning_active_sticky;
                rdata_nxt[SFI_BIT_XTAL_SIGNAL_MISSING] = crystal_signal_missing_sticky;
                rdata_nxt[SFI_BIT_XTAL_LOCK_ERROR] = crystal_lock_error_sticky;
                rdata_nxt[SFI_BIT_BUS_TIMEOUT] = host_bus_timeout_sticky;
            end
            SFI_OFS_STICKY_LOCK: begin
                rdata_nxt[SFI_BIT_PLL_UNLOCKED] = pll_unlocked_sticky;
            end
            SFI_OFS_STICKY_PLL: begin
                rdata_nxt[SFI_BIT_PLL_TUNING] = pll_tuning_active_sticky;
            end
            // mask bytes
            SFI_OFS_MASK_DEV: begin
                rdata_nxt[SFI_BIT_SYS_TUNING] = irq_mask_sys_tuning_r;
                rdata_nxt[SFI_BIT_XTAL_INPUT_MISSING] = irq_mask_crystal_input_missing_r;
                rdata_nxt[SFI_BIT_XTAL_SIGNAL_MISSING] = irq_mask_crystal_signal_missing_r;
                rdata_nxt[SFI_BIT_XTAL_LOCK_ERROR] = irq_mask_crystal_lock_error_r;
                rdata_nxt[SFI_BIT_BUS_TIMEOUT] = irq_mask_host_bus_timeout_r;
            end
            SFI_OFS_MASK_INPUT: begin
                rdata_nxt[SFI_LSB_SIGNAL_MISSING +: SFI_INPUTS] = irq_mask_input_signal_missing_r;
                rdata_nxt[SFI_LSB_FREQ_OFF +: SFI_INPUTS] = irq_mask_input_freq_off_r;
            end
            SFI_OFS_MASK_LOCK: begin
                rdata_nxt[SFI_BIT_PLL_UNLOCKED] = irq_mask_pll_unlocked_r;
                rdata_nxt[SFI_BIT_REF_ABSENT_MODE] = irq_mask_reference_absent_mode_r;
            end
            SFI_OFS_MASK_PLL: begin
                rdata_nxt[SFI_BIT_PLL_TUNING] = irq_mask_pll_tuning_r;
            end
            default: begin
                rdata_nxt = '0;
            end
        endcase
    end

    // read data is captured on the strobe and held until the next one
    // holding it lets a slow host pick the byte up in any later cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_r <= SFI_RST_RDATA;
        end else if (reg_rd) begin
            rdata_r <= rdata_nxt;
        end
    end

    // read data leaves straight from its flip-flops
    assign reg_rdata = rdata_r;

endmodule // sfi_status_irq

//--- tb/sfi_status_irq_asserts.sv
/*
 * sfi_status_irq_chk: port-level assertions for sfi_status_irq.
 * Assumes one clock and the async active-low reset of the design.
 */
`timescale 1ns/1ps

module sfi_status_irq_chk
    import sfi_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic sys_tuning_active,
    input wire logic crystal_signal_missing,
    input wire logic crystal_lock_error,
    input wire logic host_bus_timeout,
    input wire logic pll_tuning_active,
    input wire logic pll_unlocked,
    input wire logic [SFI_AW-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [SFI_DW-1:0] reg_wdata,
    input wire logic [SFI_DW-1:0] reg_rdata,
    input wire logic [SFI_INPUTS-1:0] irq_mask_input_signal_missing,
    input wire logic [SFI_INPUTS-1:0] irq_mask_input_freq_off,
    input wire logic irq_mask_reference_absent_mode,
    input wire logic irq_mask_crystal_input_missing,
    input wire logic irq_n
);
    // ************************************************
    // shadow state
    // ************************************************
    logic lock_flag_r;
    logic lock_mask_r;
    logic [7:0] live_q;
    logic [7:0] wd_q;
    logic pll_q;

    // only the lock flag and its mask are shadowed: enough to judge the pin without copying the whole map
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lock_flag_r <= 1'b0;
            lock_mask_r <= 1'b0;
        end else begin
            lock_flag_r <= pll_unlocked | (lock_flag_r & ~(reg_wr & (reg_addr == 8'h13) & ~reg_wdata[1]));
            if (reg_wr && reg_addr == 8'h19) lock_mask_r <= reg_wdata[1];
        end
    end

    // samples of the inputs one edge back, for read and write comparisons
    always_ff @(posedge clk) begin
        live_q <= {2'b00, host_bus_timeout, 1'b0, crystal_lock_error, crystal_signal_missing, 1'b0, sys_tuning_active};
        pll_q <= pll_tuning_active;
        wd_q <= reg_wdata;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence lock_fault_s;
        pll_unlocked && !lock_mask_r && !(reg_wr && reg_addr == 8'h19);
    endsequence
    sequence irq_low_s;
        ##2 !irq_n;
    endsequence

    irq_idle_a: assert property ($rose(rstn) |-> irq_n) else $error("irq pin low after reset");
    live_read_a: assert property (reg_rd && reg_addr == 8'h0c |=> reg_rdata == live_q)
        else $error("live byte wrong");
    pll_read_a: assert property (reg_rd && reg_addr == 8'h0f |=> reg_rdata == {2'b00, pll_q, 5'h00})
        else $error("pll live wrong");
    lock_irq_a: assert property (lock_fault_s |-> irq_low_s) else $error("unmasked flag gave no irq");
    sticky_read_a: assert property (reg_rd && reg_addr == 8'h13 |=>
        reg_rdata == {6'h00, $past(lock_flag_r), 1'b0}) else $error("lock sticky wrong");
    rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
    input_mask_a: assert property (reg_wr && reg_addr == 8'h18 |=>
        {irq_mask_input_freq_off, irq_mask_input_signal_missing} == wd_q) else $error("input masks not written");
    mask_keep_a: assert property (!(reg_wr && reg_addr == 8'h18) |=> $stable(irq_mask_input_freq_off))
        else $error("mask moved");
    ref_mask_a: assert property (reg_wr && reg_addr == 8'h19 |=> irq_mask_reference_absent_mode == wd_q[5])
        else $error("hold mask");
    xtal_mask_a: assert property (reg_wr && reg_addr == 8'h17 |=> irq_mask_crystal_input_missing == wd_q[1])
        else $error("xtal mask");
endmodule // sfi_status_irq_chk

bind sfi_status_irq sfi_status_irq_chk u_chk (.clk(clk), .rstn(rstn), .sys_tuning_active(sys_tuning_active),
    .crystal_signal_missing(crystal_signal_missing), .crystal_lock_error(crystal_lock_error),
    .host_bus_timeout(host_bus_timeout), .pll_tuning_active(pll_tuning_active), .pll_unlocked(pll_unlocked),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .irq_mask_input_signal_missing(irq_mask_input_signal_missing), .irq_mask_input_freq_off(irq_mask_input_freq_off),
    .irq_mask_reference_absent_mode(irq_mask_reference_absent_mode),
    .irq_mask_crystal_input_missing(irq_mask_crystal_input_missing), .irq_n(irq_n));

//--- tb/sfi_host_model.sv
/*
 * sfi_host_model: host processor on the byte register port.
 * Assumes requests launch just after a rising edge of clk.
 */
`timescale 1ns/1ps

module sfi_host_model
    import sfi_pkg::*;
(
    input wire logic clk,
    input wire logic irq_n,
    input wire logic [SFI_DW-1:0] reg_rdata,
    output logic [SFI_AW-1:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [SFI_DW-1:0] reg_wdata
);
    // ************************************************
    // register cycles
    // ************************************************
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end

    // one strobe cycle per byte; data is inverted afterwards so stale values never look valid
    task automatic reg_write(input logic [SFI_AW-1:0] a, input logic [SFI_DW-1:0] d);
        @(posedge clk);
        #1 reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk);
        #1 reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask

    // read data is registered, so it is taken just after the strobe edge
    task automatic reg_read(input logic [SFI_AW-1:0] a, output logic [SFI_DW-1:0] d);
        @(posedge clk);
        #1 reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk);
        #1 reg_rd = 1'b0;
        d = reg_rdata;
    endtask

    // servicing the pin: wait until it is asserted, then a zero to the sticky byte,
    // which lets the pin go as setting the mask does; a pin that never falls ends in the bench timeout
    task automatic service(input logic [SFI_AW-1:0] a);
        while (irq_n !== 1'b0) @(posedge clk);
        reg_write(a, 8'h00);
    endtask
endmodule // sfi_host_model

//--- tb/status_flag_interrupt_unit_tb_top.sv
/*
 * status_flag_interrupt_unit_tb_top: directed register-level tests.
 * Assumes the checker is bound in and the host model drives the port.
 */
`timescale 1ns/1ps

module status_flag_interrupt_unit_tb_top
    import sfi_pkg::*;
;
    // ************************************************
    // bench state and tables
    // ************************************************
    logic clk;
    logic rstn;
    logic [5:0] live;
    logic [SFI_AW-1:0] reg_addr;
    logic reg_wr;
    logic reg_rd;
    logic [SFI_DW-1:0] reg_wdata;
    logic [SFI_DW-1:0] reg_rdata;
    logic [3:0] m_sigmiss;
    logic [3:0] m_freqoff;
    logic m_hold;
    logic m_xin;
    logic irq_n;
    int miscompares = 0;
    int compares = 0;
    int cycles = 0;
    // per source: live byte, sticky byte, mask byte, bit value
    localparam logic [7:0] LIVE_A [6] = '{8'h0c, 8'h0c, 8'h0c, 8'h0c, 8'h0f, 8'h0e};
    localparam logic [7:0] STK_A [6] = '{8'h11, 8'h11, 8'h11, 8'h11, 8'h14, 8'h13};
    localparam logic [7:0] MSK_A [6] = '{8'h17, 8'h17, 8'h17, 8'h17, 8'h1a, 8'h19};
    localparam logic [7:0] BIT_V [6] = '{8'h01, 8'h04, 8'h08, 8'h20, 8'h20, 8'h02};
    localparam logic [7:0] RW_A [4] = '{8'h17, 8'h18, 8'h19, 8'h1a};
    localparam logic [7:0] RW_E [4] = '{8'h2f, 8'hff, 8'h22, 8'h20};
    localparam logic [7:0] NOWR_A [3] = '{8'h0c, 8'h11, 8'h55};

    sfi_status_irq DUT (.clk(clk), .rstn(rstn), .sys_tuning_active(live[0]), .crystal_signal_missing(live[1]),
        .crystal_lock_error(live[2]), .host_bus_timeout(live[3]), .pll_tuning_active(live[4]),
        .pll_unlocked(live[5]), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .irq_mask_input_signal_missing(m_sigmiss), .irq_mask_input_freq_off(m_freqoff),
        .irq_mask_reference_absent_mode(m_hold), .irq_mask_crystal_input_missing(m_xin), .irq_n(irq_n));

    sfi_host_model host (.clk(clk), .irq_n(irq_n), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ************************************************
    // comparison and closing
    // ************************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.reg_read(a, d);
        check(d, exp);
    endtask

    // irq is registered behind the flag, so two edges pass before it is looked at
    task automatic irq_chk(input logic exp);
        repeat (2) @(posedge clk);
        #1 check({7'h00, irq_n}, {7'h00, exp});
    endtask

    task automatic print_verdict();
        if (miscompares == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // a hang costs at most this many cycles; the tests need well under a thousand
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            print_verdict();
        end
    end

    // ************************************************
    // test sequence
    // ************************************************
    initial begin
        live = 6'h00;
        rstn = 1'b0;
        repeat (5) @(posedge clk);
        #1 rstn = 1'b1;
        check({7'h00, irq_n}, 8'h01);
        for (int i = 0; i < 4; i++) rd_chk(RW_A[i], 8'h00);
        for (int i = 0; i < 4; i++) host.reg_write(RW_A[i], 8'hff);
        for (int i = 0; i < 4; i++) rd_chk(RW_A[i], RW_E[i]);
        check({m_freqoff, m_sigmiss}, 8'hff);
        check({6'h00, m_hold, m_xin}, 8'h03);
        for (int i = 0; i < 4; i++) host.reg_write(RW_A[i], 8'h00);
        // read-only, sticky-one and unmapped writes must all leave zeros
        for (int i = 0; i < 3; i++) begin
            host.reg_write(NOWR_A[i], 8'hff);
            rd_chk(NOWR_A[i], 8'h00);
        end
        irq_chk(1'b1);
        // each source: fault, refused clear, mask, unmask, clear
        for (int i = 0; i < 6; i++) begin
            live[i] = 1'b1;
            rd_chk(LIVE_A[i], BIT_V[i]);
            host.reg_write(STK_A[i], 8'h00);
            rd_chk(STK_A[i], BIT_V[i]);
            check({7'h00, irq_n}, 8'h00);
            host.reg_write(MSK_A[i], BIT_V[i]);
            irq_chk(1'b1);
            rd_chk(STK_A[i], BIT_V[i]);
            host.reg_write(MSK_A[i], 8'h00);
            live[i] = 1'b0;
            irq_chk(1'b0);
            host.service(STK_A[i]);
            rd_chk(STK_A[i], 8'h00);
            rd_chk(LIVE_A[i], 8'h00);
            irq_chk(1'b1);
        end
        print_verdict();
    end
endmodule // status_flag_interrupt_unit_tb_top
